/* File: hw/hsp_host_port.sv */
// What this block does
// - Slave only; host reaches memory, boot, I/O.
// - Multiplexed address/data, 8 or 16 bits, asynchronous.
// - Internal memory access steals one core cycle.
// - Optional address auto-increment after each word.
// - Addressing style detected from latch and write.
// - Polarity caught at reset, read-only afterwards.
// - Read completes with data, no write busy.
// - Write completes with room, no write busy.
// - Mode bits 7:6; bit7 cleared, bit6 strapped.
// - Equal strap levels select Ready, else ACK.
// - Mode bits writable after reset.
// - ACK mode: assert when done, drop on release.
// - Ready mode: ready inactive inserts wait states.
// - Address cycles always acknowledged in address-cycle mode.
// - Memory select routes to internal, external, boot.
// - I/O select routes to internal I/O space.
// - Internal/external selects decoded from target page; boot select from config bit.
// - Merge up to three accesses into 24-bit word.
// - Word-start reads and word-end writes acknowledged after memory, other bytes at once.
`timescale 1ns/100ps
`include "hsp_consts.svh"

module hsp_host_port (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Host multiplexed bus
  input  wire logic [15:0] host_ad_in,
  output logic      [15:0] host_ad_out,
  output logic             host_ad_oe,
  // Host control
  input  wire logic        host_latch_enable_input,
  input  wire logic        host_write_strobe_n,
  input  wire logic        host_read_strobe_n,
  input  wire logic        host_memory_select_n,
  input  wire logic        host_io_select_n,
  // Host acknowledge pin and strap
  input  wire logic        host_acknowledge_in,
  output logic             host_acknowledge_out,
  output logic             host_acknowledge_oe,
  input  wire logic        acknowledge_polarity_strap,
  // Software configuration
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        page_write,
  input  wire logic [7:0]  page_wdata,
  output logic      [7:0]  port_config_register,
  output logic      [7:0]  target_page_register,
  output logic             address_cycle_mode,
  // Internal DMA bus
  output logic             dma_req,
  output logic             dma_write,
  output logic      [23:0] dma_addr,
  output logic      [23:0] dma_wdata,
  input  wire logic [23:0] dma_rdata,
  input  wire logic        dma_ack,
  output logic             dma_sel_int_mem,
  output logic             dma_sel_ext_mem,
  output logic             dma_sel_boot,
  output logic             dma_sel_io,
  output logic             core_cycle_steal
);
  import hsp_pkg::*;

  hsp_top_state_t s_reg;
  hsp_top_state_t s_next;

  logic        buf_wr_en;
  logic        buf_load_en;
  logic        buf_rd_en;
  logic [1:0]  buf_rd_lane;
  logic [15:0] buf_rd_data;
  logic [23:0] buf_word;
  logic [1:0]  step;
  logic [1:0]  nbytes;
  logic [2:0]  lane_end;
  logic        word_done;
  logic        rd_on;
  logic        wr_on;
  logic        ale_on;
  logic        selected;
  logic        ack_level;
  logic        is_boot;

  // --------------------------------------------------------------------------
  // Word assembly buffer
  // --------------------------------------------------------------------------
  hsp_word_buf u_buf (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .wr_en     (buf_wr_en),
    .wr_lane   (s_reg.lane),
    .wr_two    (s_reg.cfg[`HSP_CFG_WIDE_BIT]),
    .wr_data   (host_ad_in),
    .load_en   (buf_load_en),
    .load_data (dma_rdata),
    .rd_en     (buf_rd_en),
    .rd_lane   (buf_rd_lane),
    .word      (buf_word),
    .rd_data   (buf_rd_data)
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    s_next      = s_reg;
    buf_wr_en   = 1'b0;
    buf_load_en = 1'b0;
    buf_rd_en   = 1'b0;
    buf_rd_lane = s_reg.lane;
    ack_level   = 1'b0;
    is_boot     = 1'b0;

    // The first stage is seen by the second stage and, via s_next.sync, by the ack_oe register.
    s_next.meta = {~host_io_select_n, ~host_memory_select_n, host_latch_enable_input,
                   ~host_write_strobe_n, ~host_read_strobe_n};
    s_next.sync = s_reg.meta;

    rd_on    = s_reg.sync[`HSP_SYNC_RD];
    wr_on    = s_reg.sync[`HSP_SYNC_WR];
    ale_on   = s_reg.sync[`HSP_SYNC_ALE];
    selected = s_reg.sync[`HSP_SYNC_CMS] | s_reg.sync[`HSP_SYNC_CIO];

    // Bytes per host access and per internal word.
    step   = s_reg.cfg[`HSP_CFG_WIDE_BIT] ? 2'h2 : 2'h1;
    nbytes = s_reg.cfg[`HSP_CFG_NBYTES_MSB:`HSP_CFG_NBYTES_LSB];
    if (nbytes == 2'h0) begin
      nbytes = `HSP_NBYTES_FULL;
    end
    lane_end  = {1'b0, s_reg.lane} + {1'b0, step};
    word_done = lane_end >= {1'b0, nbytes};

    // Strap capture at the first edge after reset release; the host keeps
    // both pins at their strap levels until then.
    if (!s_reg.strap_done) begin
      s_next.strap_done              = 1'b1;
      s_next.cfg[`HSP_CFG_POL_BIT]   = acknowledge_polarity_strap;
      s_next.cfg[`HSP_CFG_READY_BIT] = (acknowledge_polarity_strap
                                        == host_acknowledge_in);
      s_next.cfg[`HSP_CFG_MODE7_BIT] = 1'b0;
    end else if (cfg_write) begin
      // The polarity bit is kept; all other bits follow software.
      s_next.cfg = {cfg_wdata[7:6], s_reg.cfg[`HSP_CFG_POL_BIT], cfg_wdata[4:0]};
    end
    if (page_write) begin
      s_next.page = page_wdata;
    end

    s_next.core_steal = 1'b0;

    case (s_reg.st)
      st_idle: begin
        s_next.ad_oe = 1'b0;
        if (ale_on && !rd_on && !wr_on) begin
          // Latch pulse with no strobe: address follows the bus while high.
          s_next.addr     = host_ad_in;
          s_next.acc_mode = 1'b0;
          s_next.lane     = 2'h0;
        end else if (selected && wr_on && ale_on) begin
          // Write strobe with latch high is an address cycle.
          s_next.addr     = host_ad_in;
          s_next.acc_mode = 1'b1;
          s_next.lane     = 2'h0;
          s_next.st       = st_done;
        end else if (selected && (rd_on || wr_on)) begin
          s_next.is_io   = s_reg.sync[`HSP_SYNC_CIO];
          s_next.is_read = rd_on;
          if (wr_on) begin
            buf_wr_en = 1'b1;
            if (!word_done) begin
              s_next.lane = lane_end[1:0];
              s_next.st   = st_done;
            end else begin
              // Write of the assembled word; the host is not acknowledged and the sequencer stays
              // busy until the bus takes it, so no new access overlaps.
              s_next.dma_req   = 1'b1;
              s_next.dma_write = 1'b1;
              s_next.st        = st_wait;
            end
          end else if (s_reg.lane == 2'h0) begin
            // First byte of a word starts a whole-word fetch.
            s_next.dma_req   = 1'b1;
            s_next.dma_write = 1'b0;
            s_next.st        = st_wait;
          end else begin
            buf_rd_en = 1'b1;
            s_next.st = st_rdout;
          end
          if (s_next.dma_req) begin
            is_boot           = !s_next.is_io && s_reg.cfg[`HSP_CFG_BOOT_BIT];
            s_next.dma_addr   = {s_reg.page, s_reg.addr};
            s_next.sel_io     = s_next.is_io;
            s_next.sel_boot   = is_boot;
            s_next.sel_int    = !s_next.is_io && !is_boot
                                && s_reg.page < `HSP_INT_PAGE_LIMIT;
            s_next.sel_ext    = !s_next.is_io && !is_boot
                                && !(s_reg.page < `HSP_INT_PAGE_LIMIT);
            s_next.core_steal = s_next.sel_int;
          end
        end
      end
      st_wait: begin
        if (dma_ack) begin
          s_next.dma_req = 1'b0;
          if (s_reg.is_read) begin
            buf_load_en = 1'b1;
            s_next.st   = st_rdout;
          end else begin
            s_next.lane = 2'h0;
            if (s_reg.cfg[`HSP_CFG_AUTOINC_BIT]) begin
              s_next.addr = s_reg.addr + `HSP_ADDR_STEP;
            end
            s_next.st = st_done;
          end
        end
      end
      st_rdout: begin
        s_next.ad_oe = 1'b1;
        if (word_done) begin
          s_next.lane = 2'h0;
          if (s_reg.cfg[`HSP_CFG_AUTOINC_BIT]) begin
            s_next.addr = s_reg.addr + `HSP_ADDR_STEP;
          end
        end else begin
          s_next.lane = lane_end[1:0];
        end
        s_next.st = st_done;
      end
      st_done: begin
        if (!rd_on && !wr_on) begin
          s_next.ad_oe = 1'b0;
          s_next.st    = st_idle;
        end
      end
      default: begin
        s_next.st = st_idle;
      end
    endcase

    // Acknowledge level. In Ready mode the line idles active, so a host
    // that samples it within the synchroniser delay may finish early; such
    // hosts must allow four clocks before sampling.
    if (s_next.cfg[`HSP_CFG_READY_BIT]) begin
      ack_level = (s_next.st == st_done)
                  || (s_next.st == st_idle && !(selected && (rd_on || wr_on)));
    end else begin
      ack_level = (s_next.st == st_done);
    end
    s_next.ack_out = s_next.cfg[`HSP_CFG_POL_BIT] ? ack_level : ~ack_level;
    // The pin is left to the host during the strap window.
    s_next.ack_oe  = s_reg.strap_done && (s_next.sync[`HSP_SYNC_CMS]
                                          | s_next.sync[`HSP_SYNC_CIO]);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg      <= '0;
      s_reg.st   <= st_idle;
      s_reg.cfg  <= `HSP_CFG_RESET;
      s_reg.page <= `HSP_PAGE_RESET;
      s_reg.addr <= `HSP_ADDR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign host_ad_out          = buf_rd_data;
  assign host_ad_oe           = s_reg.ad_oe;
  assign host_acknowledge_out = s_reg.ack_out;
  assign host_acknowledge_oe  = s_reg.ack_oe;
  assign port_config_register = s_reg.cfg;
  assign target_page_register = s_reg.page;
  assign address_cycle_mode   = s_reg.acc_mode;
  assign dma_req              = s_reg.dma_req;
  assign dma_write            = s_reg.dma_write;
  assign dma_addr             = s_reg.dma_addr;
  assign dma_wdata            = buf_word;
  assign dma_sel_int_mem      = s_reg.sel_int;
  assign dma_sel_ext_mem      = s_reg.sel_ext;
  assign dma_sel_boot         = s_reg.sel_boot;
  assign dma_sel_io           = s_reg.sel_io;
  assign core_cycle_steal     = s_reg.core_steal;

endmodule

/* File: hw/hsp_word_buf.sv */
`timescale 1ns/100ps
`include "hsp_consts.svh"

module hsp_word_buf (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Byte writes from the host side
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_lane,
  input  wire logic        wr_two,
  input  wire logic [15:0] wr_data,
  // Whole-word load from the internal bus
  input  wire logic        load_en,
  input  wire logic [23:0] load_data,
  // Registered read port
  input  wire logic        rd_en,
  input  wire logic [1:0]  rd_lane,
  output logic      [23:0] word,
  output logic      [15:0] rd_data
);
  import hsp_pkg::*;

  hsp_buf_state_t s_reg;
  hsp_buf_state_t s_next;
  logic [2:0][7:0] byte_next;
  logic [31:0]     src;

  // --------------------------------------------------------------------------
  // Per-byte update
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lane
      always_comb begin
        byte_next[g] = s_reg.bytes[g];
        if (load_en) begin
          byte_next[g] = load_data[8*g +: 8];
        end else if (wr_en && wr_lane == 2'(g)) begin
          byte_next[g] = wr_data[7:0];
        end else if (wr_en && wr_two && wr_lane + 2'h1 == 2'(g)) begin
          byte_next[g] = wr_data[15:8];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // A load bypasses into the read register so fetched data is ready next cycle.
  always_comb begin
    s_next       = s_reg;
    s_next.bytes = byte_next;
    src          = {8'h00, (load_en ? load_data : s_reg.bytes)};
    if (rd_en || load_en) begin
      s_next.rd_data = src[8*rd_lane +: 16];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign word    = s_reg.bytes;
  assign rd_data = s_reg.rd_data;

endmodule

/* File: pkg/hsp_consts.svh */
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Port configuration register fields
// ----------------------------------------------------------------------------
`define HSP_CFG_WIDE_BIT     0
`define HSP_CFG_NBYTES_LSB   1
`define HSP_CFG_NBYTES_MSB   2
`define HSP_CFG_AUTOINC_BIT  3
`define HSP_CFG_BOOT_BIT     4
`define HSP_CFG_POL_BIT      5
`define HSP_CFG_READY_BIT    6
`define HSP_CFG_MODE7_BIT    7
`define HSP_CFG_RESET        8'h06
`define HSP_PAGE_RESET       8'h00

// ----------------------------------------------------------------------------
// Address decode and sizes
// ----------------------------------------------------------------------------
`define HSP_INT_PAGE_LIMIT   8'h01
`define HSP_ADDR_RESET       16'h0000
`define HSP_ADDR_STEP        16'h0001
`define HSP_NBYTES_FULL      2'h3

// ----------------------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------------------
`define HSP_SYNC_RD          0
`define HSP_SYNC_WR          1
`define HSP_SYNC_ALE         2
`define HSP_SYNC_CMS         3
`define HSP_SYNC_CIO         4

`endif

/* File: pkg/hsp_pkg.sv */
package hsp_pkg;

  // --------------------------------------------------------------------------
  // Access sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_rdout,
    st_done
  } hsp_st_t;

  // --------------------------------------------------------------------------
  // Whole state of the port
  // --------------------------------------------------------------------------
  typedef struct packed {
    hsp_st_t     st;
    logic [4:0]  meta;
    logic [4:0]  sync;
    logic        strap_done;
    logic [7:0]  cfg;
    logic [7:0]  page;
    logic [15:0] addr;
    logic [1:0]  lane;
    logic        is_io;
    logic        is_read;
    logic        acc_mode;
    logic        ack_out;
    logic        ack_oe;
    logic        ad_oe;
    logic        dma_req;
    logic        dma_write;
    logic [23:0] dma_addr;
    logic        sel_int;
    logic        sel_ext;
    logic        sel_boot;
    logic        sel_io;
    logic        core_steal;
  } hsp_top_state_t;

  // --------------------------------------------------------------------------
  // Word assembly buffer state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] bytes;
    logic [15:0]     rd_data;
  } hsp_buf_state_t;

endpackage

/* File: tb/host_slave_port_ack_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("unexpected at %0t: %h, expected %h", $time, (a), (e)); \
    end \
  end

module host_slave_port_ack_tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        strap = 1'b1;
  logic        ack_strap = 1'b0;
  logic        cfg_write = 1'b0;
  logic        page_write = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [23:0] dma_rdata = 24'hc3b2a1;
  logic        dma_ack = 1'b0;
  logic [15:0] q;
  logic [23:0] r;
  logic [23:0] got_w, got_a;
  logic [3:0]  got_s;
  logic        got_wr;
  wire         latch, wr_n, rd_n, mem_n, io_n, ad_oe, ack_out, ack_oe;
  wire         cyc_mode, dma_req, dma_write, steal;
  wire [15:0]  ad_drv, ad_out;
  wire [7:0]   cfg, page;
  wire [23:0]  dma_addr, dma_wdata;
  wire [3:0]   sels;
  int          mismatches = 0;
  int          n_compared = 0;
  int          steals = 0;
  int          dly = 0;
  int          wcnt = 0;
  wire [15:0]  ad_pin = ad_oe ? ad_out : ad_drv;
  wire         ack_pin = ack_oe ? ack_out : ack_strap;

  always #25 clk_sys = ~clk_sys;

  hsp_host_port i_hsp_host_port (
    .clk_sys(clk_sys), .reset(reset),
    .host_ad_in(ad_pin), .host_ad_out(ad_out), .host_ad_oe(ad_oe),
    .host_latch_enable_input(latch), .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
    .host_memory_select_n(mem_n), .host_io_select_n(io_n),
    .host_acknowledge_in(ack_pin), .host_acknowledge_out(ack_out),
    .host_acknowledge_oe(ack_oe), .acknowledge_polarity_strap(strap),
    .cfg_write(cfg_write), .cfg_wdata(wdata), .page_write(page_write), .page_wdata(wdata),
    .port_config_register(cfg), .target_page_register(page), .address_cycle_mode(cyc_mode),
    .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
    .dma_rdata(dma_rdata), .dma_ack(dma_ack), .dma_sel_int_mem(sels[3]),
    .dma_sel_ext_mem(sels[2]), .dma_sel_boot(sels[1]), .dma_sel_io(sels[0]),
    .core_cycle_steal(steal));

  hsp_host_model i_hsp_host_model (
    .clk_sys(clk_sys), .pol(cfg[5]), .ack_pin(ack_pin), .ad_pin(ad_pin), .latch(latch),
    .wr_n(wr_n), .rd_n(rd_n), .mem_n(mem_n), .io_n(io_n), .ad_drv(ad_drv));

  // ------
  // Memory stand-in; the delay keeps the port waiting on word-end writes and word-start reads.
  // ------
  always @(posedge clk_sys) begin
    dma_ack <= 1'b0;
    if (steal) steals++;
    if (dma_req && !dma_ack && wcnt >= dly) begin
      dma_ack <= 1'b1;
      wcnt    <= 0;
      got_w   <= dma_wdata;
      got_a   <= dma_addr;
      got_s   <= sels;
      got_wr  <= dma_write;
    end else if (dma_req && !dma_ack) begin
      wcnt <= wcnt + 1;
    end
  end

  task automatic close_out;
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset(input logic s, input logic a);
    @(posedge clk_sys);
    reset     <= 1'b1;
    strap     <= s;
    ack_strap <= a;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(cfg, 8'h06 | {1'b0, s == a, s, 5'h00})
    `CHK(page, 8'h00)
  endtask

  task automatic set_reg(input logic pg, input logic [7:0] v);
    @(posedge clk_sys);
    cfg_write  <= !pg;
    page_write <= pg;
    wdata      <= v;
    @(posedge clk_sys);
    cfg_write  <= 1'b0;
    page_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr3(input logic io, input logic [23:0] w);
    for (int i = 0; i < 3; i++)
      i_hsp_host_model.cyc(1'b0, 1'b1, io, {8'h00, w[8*i+:8]}, q);
    `CHK(got_w, w)
  endtask

  task automatic rd3;
    for (int i = 0; i < 3; i++) begin
      i_hsp_host_model.cyc(1'b0, 1'b0, 1'b0, 16'h0000, q);
      r[8*i+:8] = q[7:0];
    end
  endtask

  task automatic expect_dma(input logic [23:0] a, input logic [3:0] s, input logic w);
    `CHK(got_a, a)
    `CHK(got_s, s)
    `CHK(got_wr, w)
  endtask

  initial begin
    for (int i = 0; i < 4; i++) do_reset(i[1], i[0]);
    do_reset(1'b1, 1'b0);
    set_reg(1'b0, 8'h0e);
    `CHK(cfg, 8'h2e)
    i_hsp_host_model.addr_latch(16'h0010);
    `CHK(cyc_mode, 1'b0)
    wr3(1'b0, 24'h332211);
    expect_dma(24'h000010, 4'b1000, 1'b1);
    dly = 6;
    wr3(1'b0, 24'h665544);
    expect_dma(24'h000011, 4'b1000, 1'b1);
    rd3;
    `CHK(r, 24'hc3b2a1)
    expect_dma(24'h000012, 4'b1000, 1'b0);
    `CHK(steals, 3)
    i_hsp_host_model.cyc(1'b1, 1'b1, 1'b0, 16'h0200, q);
    `CHK(cyc_mode, 1'b1)
    set_reg(1'b1, 8'h03);
    wr3(1'b0, 24'h0a0b0c);
    expect_dma(24'h030200, 4'b0100, 1'b1);
    set_reg(1'b0, 8'h1e);
    wr3(1'b0, 24'h0d0e0f);
    expect_dma(24'h030201, 4'b0010, 1'b1);
    wr3(1'b1, 24'h123456);
    expect_dma(24'h030202, 4'b0001, 1'b1);
    `CHK(steals, 3)
    set_reg(1'b0, 8'h0f);
    i_hsp_host_model.cyc(1'b0, 1'b1, 1'b0, 16'h2211, q);
    i_hsp_host_model.cyc(1'b0, 1'b1, 1'b0, 16'h9933, q);
    `CHK(got_w, 24'h332211)
    expect_dma(24'h030203, 4'b0100, 1'b1);
    do_reset(1'b0, 1'b0);
    set_reg(1'b0, 8'hee);
    `CHK(cfg, 8'hce)
    i_hsp_host_model.addr_latch(16'h0040);
    wr3(1'b0, 24'h778899);
    expect_dma(24'h000040, 4'b1000, 1'b1);
    rd3;
    `CHK(r, 24'hc3b2a1)
    `CHK(i_hsp_host_model.n_late, 0)
    close_out;
  end

  // The run needs a few hundred clocks; this leaves ample room for wait states.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out;
  end
endmodule

/* File: tb/hsp_host_model.sv */
`timescale 1ns/100ps
module hsp_host_model (
  // Clock
  input  logic        clk_sys,
  // Pins the host watches
  input  logic        pol,
  input  logic        ack_pin,
  input  logic [15:0] ad_pin,
  // Pins the host drives
  output logic        latch,
  output logic        wr_n,
  output logic        rd_n,
  output logic        mem_n,
  output logic        io_n,
  output logic [15:0] ad_drv
);
  int n_late = 0;

  initial begin
    latch = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    mem_n = 1'b1;
    io_n = 1'b1;
    ad_drv = 16'h0000;
  end

  // ------
  // Host cycles
  // ------
  // The strobe is held until the active level is seen at an edge; the first look is
  // four clocks in, since an idle ready line reads active before the port has synced.
  task automatic cyc(input logic lat, input logic wr, input logic io,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_sys);
    latch  <= lat;
    ad_drv <= wr ? d : ~d;
    wr_n   <= !wr;
    rd_n   <= wr;
    mem_n  <= io;
    io_n   <= !io;
    repeat (4) @(posedge clk_sys);
    n = 0;
    while (ack_pin !== pol && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 60) n_late++;
    q = ad_pin;
    latch  <= 1'b0;
    wr_n   <= 1'b1;
    rd_n   <= 1'b1;
    mem_n  <= 1'b1;
    io_n   <= 1'b1;
    ad_drv <= ~ad_drv;
    repeat (4) @(posedge clk_sys);
  endtask

  // Address stays on the bus after the latch falls so the synced latch still sees it.
  task automatic addr_latch(input logic [15:0] a);
    @(posedge clk_sys);
    latch  <= 1'b1;
    ad_drv <= a;
    repeat (4) @(posedge clk_sys);
    latch <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ad_drv <= ~a;
  endtask
endmodule

/* File: tb/hsp_port_sva.sv */
`timescale 1ns/100ps
module hsp_port_sva (
  // Clock and reset
  input logic        clk_sys,
  input logic        reset,
  // Host side
  input logic        host_write_strobe_n,
  input logic        host_read_strobe_n,
  input logic        host_memory_select_n,
  input logic        host_io_select_n,
  input logic        host_acknowledge_in,
  input logic        host_acknowledge_out,
  input logic        host_acknowledge_oe,
  input logic        acknowledge_polarity_strap,
  // Configuration
  input logic [7:0]  port_config_register,
  input logic [7:0]  target_page_register,
  // Internal bus
  input logic        dma_req,
  input logic        dma_write,
  input logic [23:0] dma_addr,
  input logic        dma_ack,
  input logic        dma_sel_int_mem,
  input logic        dma_sel_ext_mem,
  input logic        dma_sel_boot,
  input logic        dma_sel_io,
  input logic        core_cycle_steal
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic pol;
  logic idle;
  logic act;
  logic [3:0] sels;
  assign pol  = port_config_register[5];
  assign idle = host_read_strobe_n && host_write_strobe_n;
  assign act  = host_acknowledge_oe && (host_acknowledge_out == pol);
  assign sels = {dma_sel_int_mem, dma_sel_ext_mem, dma_sel_boot, dma_sel_io};

  strap_capture_a: assert property (
    $fell(reset) |=> port_config_register[7:5] == {1'b0, $past(acknowledge_polarity_strap)
      == $past(host_acknowledge_in), $past(acknowledge_polarity_strap)})
    else $error("strap capture wrong");
  pol_locked_a: assert property (
    !$fell(reset) |=> $stable(pol)) else $error("polarity bit changed");
  wait_inactive_a: assert property (
    dma_req && $past(dma_req) |-> !act) else $error("acknowledge active during fetch");
  ack_release_a: assert property (
    (!port_config_register[6] && idle) [*4] |=> !act) else $error("acknowledge not removed");
  ready_idle_a: assert property (
    (port_config_register[6] && idle && !dma_req) [*4] |=> !host_acknowledge_oe || act)
    else $error("ready inactive when idle");
  unselected_quiet_a: assert property (
    (host_memory_select_n && host_io_select_n) [*4] |=> !host_acknowledge_oe)
    else $error("acknowledge driven without select");
  req_hold_a: assert property (
    dma_req && !dma_ack |=> dma_req && $stable(dma_addr)) else $error("request dropped");
  req_drop_a: assert property (
    dma_ack |=> !dma_req) else $error("request held after answer");
  steal_pulse_a: assert property (
    core_cycle_steal == ($rose(dma_req) && dma_sel_int_mem)) else $error("steal pulse wrong");
  route_onehot_a: assert property (
    dma_req |-> $onehot(sels)) else $error("space select not one-hot");
  int_decode_a: assert property (
    dma_req && !dma_sel_io && !dma_sel_boot |-> dma_sel_int_mem == (dma_addr[23:16] == 8'h00))
    else $error("internal decode wrong");
  page_addr_a: assert property (
    dma_req |-> dma_addr[23:16] == target_page_register) else $error("page not on address");

  cover property (dma_req && dma_write);
  cover property (dma_req && !dma_write);
  cover property (core_cycle_steal);
endmodule

bind hsp_host_port hsp_port_sva i_hsp_port_sva (.*);
